// ---- inc/crs_pkg.sv ----
package crs_pkg;
	localparam int          STRAP_W          = 5;
	localparam logic [7:0]  CFG_OFFSET       = 8'hE2;
	// Byte 0xE2 lives in aligned word 0xE0, lane 2
	localparam logic [11:0] ADDR_STRAP_WORD  = 12'h0E0;
	localparam logic [11:0] ADDR_MODE_WORD   = 12'h0E4;
	localparam int          STRAP_LANE_LSB   = 16;
	localparam int          STRAP_FIELD_LSB  = 4;
	localparam logic [4:0]  CODE_CLOCK_OFF   = 5'h1F;
	localparam logic [4:0]  CODE_BYPASS_ONE  = 5'h07;
	localparam logic [4:0]  CODE_BYPASS_ONE2 = 5'h03;
	localparam logic [4:0]  CODE_BYPASS_DUAL = 5'h06;
	localparam logic [4:0]  STRAP_RESET      = 5'h00;
	localparam logic [31:0] SLV_ERR_DATA     = 32'h0000_0000;

	typedef enum logic [2:0] {
		CRS_PLL,
		CRS_OFF,
		CRS_BYP_SINGLE,
		CRS_BYP_DUAL,
		CRS_RESERVED
	} crs_mode_t;

	typedef struct packed {
		logic periph_from_ref;
		logic cpu_from_ref;
		logic cpu_from_osc;
		logic periph_pll_on;
		logic cpu_pll_on;
		logic ratio_one_to_one;
		logic clocks_stopped;
	} crs_clk_sel_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} crs_apb_req_t;
endpackage

// ---- core/crs_clock_ratio.sv ----
// The APB register port was decided locally.
`timescale 1ns/1ps
// How it works
// - Strap all ones stops every clock; both multipliers off.
// - Captured strap bits 3..0 readable in bits 7..4 of config byte 0xE2.
// - Single bypass: cpu from reference, periph PLL off, 1:1 ratio.
// - Dual bypass: periph from reference, cpu from oscillator, PLLs off.
module crs_clock_ratio
	import crs_pkg::*;
(
	input  wire logic         core_clk,
	input  wire logic         arst_n,
	input  wire logic         clk_en,
	input  wire logic [4:0]   ratio_strap,
	input  wire crs_apb_req_t apb_req,
	output logic              pready,
	output logic [31:0]       prdata,
	output logic              pslverr,
	output crs_clk_sel_t      clk_sel,
	output logic [4:0]        strap_held
);

	function automatic crs_mode_t decode_mode(input logic [4:0] code);
		crs_mode_t m;
		m = CRS_PLL;
		if (code == CODE_CLOCK_OFF)
			m = CRS_OFF;
		else if (code == CODE_BYPASS_DUAL)
			m = CRS_BYP_DUAL;
		else if (code == CODE_BYPASS_ONE || code == CODE_BYPASS_ONE2)
			m = CRS_BYP_SINGLE;
		else if (code == 5'h05 || code == 5'h1E)
			m = CRS_RESERVED;
		return m;
	endfunction

	logic [4:0]   sync1_reg;
	logic [4:0]   sync2_reg;
	logic         in_reset_reg;
	logic         in_reset_next;
	logic [4:0]   strap_reg;
	logic [4:0]   strap_next;
	crs_mode_t    mode_reg;
	crs_mode_t    mode_next;
	crs_clk_sel_t sel_next;
	logic         pready_next;
	logic [31:0]  prdata_next;
	logic         pslverr_next;

	// Strap pins are asynchronous to core_clk
	// No reset here: the strap must flow through while reset is held,
	// else the capture edge would only ever see the reset value
	always_ff @(posedge core_clk) begin
		if (clk_en) begin
			sync1_reg <= ratio_strap;
			sync2_reg <= sync1_reg;
		end
	end

	// Capture window at release
	// Sampled on the first enabled edge after release; never again
	always_comb begin
		in_reset_next = 1'b0;
		strap_next    = in_reset_reg ? sync2_reg : strap_reg;
		mode_next     = in_reset_reg ? decode_mode(sync2_reg) : mode_reg;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			in_reset_reg <= 1'b1;
			strap_reg    <= STRAP_RESET;
			mode_reg     <= CRS_PLL;
		end else if (clk_en) begin
			in_reset_reg <= in_reset_next;
			strap_reg    <= strap_next;
			mode_reg     <= mode_next;
		end
	end

	always_comb begin
		sel_next = '0;
		unique case (mode_next)
			CRS_PLL: begin
				sel_next.periph_pll_on = 1'b1;
				sel_next.cpu_pll_on    = 1'b1;
			end
			CRS_OFF: begin
				sel_next.clocks_stopped = 1'b1;
			end
			CRS_BYP_SINGLE: begin
				sel_next.cpu_from_ref     = 1'b1;
				sel_next.cpu_pll_on       = 1'b1;
				sel_next.ratio_one_to_one = 1'b1;
			end
			// Relies on board keeping both clocks aligned
			CRS_BYP_DUAL: begin
				sel_next.periph_from_ref  = 1'b1;
				sel_next.cpu_from_osc     = 1'b1;
				sel_next.ratio_one_to_one = 1'b1;
			end
			// Reserved code: hold clocks stopped, safest choice
			CRS_RESERVED: begin
				sel_next.clocks_stopped = 1'b1;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			clk_sel    <= '0;
			strap_held <= STRAP_RESET;
		end else if (clk_en) begin
			clk_sel    <= sel_next;
			strap_held <= strap_next;
		end
	end

	// APB slave: one wait state, answer registered
	always_comb begin
		pready_next  = 1'b0;
		prdata_next  = '0;
		pslverr_next = 1'b0;
		if (apb_req.psel && apb_req.penable && !pready) begin
			pready_next = 1'b1;
			// Registers are read-only; writes are refused
			if (apb_req.pwrite) begin
				pslverr_next = 1'b1;
			end else if (apb_req.paddr == ADDR_STRAP_WORD) begin
				// Strap bits 3..0 in byte 0xE2 bits 7..4
				prdata_next[STRAP_LANE_LSB+STRAP_FIELD_LSB +: 4] =
					strap_reg[3:0];
			end else if (apb_req.paddr == ADDR_MODE_WORD) begin
				prdata_next = {24'h000000, 3'h0, strap_reg};
				prdata_next[10:8] = mode_reg;
			end else begin
				prdata_next  = SLV_ERR_DATA;
				pslverr_next = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready  <= pready_next;
			prdata  <= prdata_next;
			pslverr <= pslverr_next;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	AST_OFF_STOPS: assert property (
		mode_reg == CRS_OFF |-> clk_sel.clocks_stopped
			&& !clk_sel.periph_pll_on && !clk_sel.cpu_pll_on)
		else $error("clock off mode left a clock running");
	AST_STRAP_READ: assert property (
		apb_req.psel && apb_req.penable && !pready && !apb_req.pwrite
			&& apb_req.paddr == ADDR_STRAP_WORD && clk_en
		|=> pready && prdata[23:20] == strap_reg[3:0])
		else $error("strap field read wrong");
	AST_SINGLE: assert property (
		mode_reg == CRS_BYP_SINGLE |-> clk_sel.cpu_from_ref
			&& !clk_sel.periph_pll_on && clk_sel.ratio_one_to_one)
		else $error("single bypass selection wrong");
	AST_DUAL: assert property (
		mode_reg == CRS_BYP_DUAL |-> clk_sel.periph_from_ref
			&& clk_sel.cpu_from_osc && !clk_sel.cpu_pll_on
			&& !clk_sel.periph_pll_on)
		else $error("dual bypass selection wrong");
	AST_HOLD: assert property (
		!in_reset_reg && !$past(in_reset_reg) |-> $stable(strap_reg)
			&& $stable(mode_reg))
		else $error("strap changed after capture");
	AST_HELD_OUT: assert property (
		!in_reset_reg |-> strap_held == strap_reg)
		else $error("held strap output mismatch");
	AST_RESERVED: assert property (
		mode_reg == CRS_RESERVED |-> clk_sel.clocks_stopped)
		else $error("reserved code not stopped");
	AST_PREADY_PULSE: assert property (
		pready |=> !pready)
		else $error("pready held over two cycles");

	AST_WRITE_REFUSED: assert property (
		apb_req.psel && apb_req.penable && !pready && apb_req.pwrite
			&& clk_en
		|=> pready && pslverr && prdata == '0)
		else $error("register write was not refused");
	AST_UNMAPPED: assert property (
		apb_req.psel && apb_req.penable && !pready && clk_en
			&& apb_req.paddr != ADDR_STRAP_WORD
			&& apb_req.paddr != ADDR_MODE_WORD
		|=> pready && pslverr)
		else $error("unmapped access not flagged");
	AST_PREADY_ASKED: assert property (
		$rose(pready) |-> $past(apb_req.psel) && $past(apb_req.penable))
		else $error("pready without an access phase");
	AST_CAPTURE: assert property (
		in_reset_reg && clk_en |=> !in_reset_reg
			&& strap_reg == $past(sync2_reg))
		else $error("strap not captured at first enabled edge");
	// Frozen clock enable must stall every register
	AST_FREEZE: assert property (
		!clk_en |=> $stable(clk_sel) && $stable(strap_held)
			&& $stable(pready) && $stable(mode_reg))
		else $error("state moved while clock enable low");

	COV_OFF:    cover property (mode_reg == CRS_OFF);
	COV_SINGLE: cover property (mode_reg == CRS_BYP_SINGLE);
	COV_DUAL:   cover property (mode_reg == CRS_BYP_DUAL);
	COV_READ:   cover property (pready && !pslverr);
	COV_FROZEN: cover property (!clk_en && in_reset_reg);
endmodule

// ---- verif/crs_board.sv ----
`timescale 1ns/1ps
module crs_board (
	input  wire logic [4:0] code,
	input  wire logic       src_clk,
	output logic [4:0]      ratio_strap,
	output logic            pci_ref_clk,
	output logic            core_osc_clock_in
);
	assign ratio_strap = (code == 5'h05 || code == 5'h1E) ? 5'h00 : code;
	// one source keeps both clocks in step
	assign pci_ref_clk       = src_clk;
	assign core_osc_clock_in = src_clk;
endmodule

// ---- verif/clock_ratio_strap_select_test.sv ----
`timescale 1ns/1ps
module clock_ratio_strap_select_test;
	import crs_pkg::*;
	logic         core_clk = 0;
	logic         arst_n = 0;
	logic         clk_en = 1'b1;
	logic [4:0]   code = 0;
	logic [4:0]   ratio_strap;
	crs_apb_req_t req = '0;
	logic         pready;
	logic         pslverr;
	logic [31:0]  prdata;
	crs_clk_sel_t clk_sel;
	logic [4:0]   strap_held;
	logic [32:0]  exp_q[$];
	int           n_errors = 0;
	int           n_checks = 0;
	int           cyc = 0;
	int           seed = 32'h121b;
	always #5 core_clk = ~core_clk;
	crs_board i_crs_board (.code(code), .src_clk(core_clk),
		.ratio_strap(ratio_strap), .pci_ref_clk(),
		.core_osc_clock_in());
	crs_clock_ratio i_crs_clock_ratio (.core_clk(core_clk),
		.arst_n(arst_n), .clk_en(clk_en), .ratio_strap(ratio_strap),
		.apb_req(req), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .clk_sel(clk_sel), .strap_held(strap_held));
	task automatic results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	// Expected {mode, clk_sel} per strap code
	function automatic logic [9:0] sel_of(input logic [4:0] c);
		case (c)
			5'h1F: return {3'h1, 7'h01};
			5'h03, 5'h07: return {3'h2, 7'h26};
			5'h06: return {3'h3, 7'h52};
			default: return {3'h0, 7'h0C};
		endcase
	endfunction
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [32:0] e);
		exp_q.push_back(e);
		req <= '{1'b1, 1'b0, w, a, 32'($random(seed))};
		@(posedge core_clk);
		req.penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		req <= '0;
		@(posedge core_clk);
	endtask
	// Bus answers against queued notes
	always @(posedge core_clk) if (pready === 1'b1) begin
		if (exp_q.size() == 0) begin
			n_errors++;
			$display("wrong value at %0t: answer with no request", $time);
		end else
			cmp({pslverr, prdata}, exp_q.pop_front());
	end
	always @(posedge core_clk) if (++cyc > 3000) begin
		n_errors++;
		results();
	end
	initial begin
		logic [4:0] c;
		logic [9:0] e;
		for (int i = 0; i < 32; i++) begin
			c = (i == 5 || i == 30) ? 5'h00 : 5'(i);
			e = sel_of(c);
			arst_n <= 1'b0;
			code <= 5'(i);
			repeat (12) @(posedge core_clk);
			arst_n <= 1'b1;
			// Odd rounds delay the capture edge by a frozen enable
			clk_en <= !i[0];
			repeat (3) @(posedge core_clk);
			code <= 5'($random(seed));
			clk_en <= 1'b1;
			repeat (3) @(posedge core_clk);
			cmp({clk_sel, strap_held}, {e[6:0], c});
			apb(1'b1, ADDR_STRAP_WORD, {1'b1, 32'h0});
			apb(1'b0, ADDR_STRAP_WORD, {9'h0, c[3:0], 20'h0});
			apb(1'b0, ADDR_MODE_WORD, {22'h0, e[9:7], 3'h0, c});
			apb(1'b0, 12'h100, {1'b1, 32'h0});
		end
		repeat (2) @(posedge core_clk);
		results();
	end
endmodule
